// ===== rtl/hprs_params.svh
// constants of the host power and reset switch controller
`ifndef HPRS_PARAMS_SVH
`define HPRS_PARAMS_SVH

// ----------------------------------------------------------------
// command and reply codes
// ----------------------------------------------------------------
`define HPRS_CMD_SWITCH_CFG 8'h1C
`define HPRS_RSP_SWITCH_CFG 8'h5C

// ----------------------------------------------------------------
// function mask bit positions
// ----------------------------------------------------------------
`define HPRS_BIT_AUTO_POL 0
`define HPRS_BIT_RESET_INV 1
`define HPRS_BIT_POWER_INV 2
`define HPRS_BIT_BLANK 4
`define HPRS_BIT_KEY_RESET 5
`define HPRS_BIT_KEY_PWR_ON 6
`define HPRS_BIT_KEY_PWR_OFF 7

// ----------------------------------------------------------------
// reset values of the configuration
// ----------------------------------------------------------------
`define HPRS_MASK_RST 8'h00
`define HPRS_LEN_RST 8'h20
`define HPRS_SENSE_SEL_RST 1'b1

// ----------------------------------------------------------------
// synchroniser bit positions
// ----------------------------------------------------------------
`define HPRS_SY_CHECK 0
`define HPRS_SY_CANCEL 1
`define HPRS_SY_SENSE_GPIO 2
`define HPRS_SY_SENSE_HDR 3
`define HPRS_SY_PWR_LINE 4
`define HPRS_SY_RST_LINE 5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HPRS_CLK_PERIOD_NS 10
`define HPRS_TICK_NS 31250000
`define HPRS_TICK_CYCLES (`HPRS_TICK_NS / `HPRS_CLK_PERIOD_NS)
`define HPRS_TICKS_PER_S 32
`define HPRS_RESET_HOLD_MS 4000
`define HPRS_PWR_ON_PRESS_MS 250
`define HPRS_PWR_OFF_HOLD_MS 4000
`define HPRS_RESET_PULSE_MS 1000
`define HPRS_PWR_PULSE_DEF_MS 1000
`define HPRS_PWR_EXTEND_MS 5000
`define HPRS_RESET_HOLD_TICKS ((`HPRS_RESET_HOLD_MS * `HPRS_TICKS_PER_S + 999) / 1000)
`define HPRS_PWR_ON_PRESS_TICKS ((`HPRS_PWR_ON_PRESS_MS * `HPRS_TICKS_PER_S + 999) / 1000)
`define HPRS_PWR_OFF_HOLD_TICKS ((`HPRS_PWR_OFF_HOLD_MS * `HPRS_TICKS_PER_S + 999) / 1000)
`define HPRS_RESET_PULSE_TICKS ((`HPRS_RESET_PULSE_MS * `HPRS_TICKS_PER_S + 999) / 1000)
`define HPRS_PWR_PULSE_DEF_TICKS ((`HPRS_PWR_PULSE_DEF_MS * `HPRS_TICKS_PER_S + 999) / 1000)
`define HPRS_PWR_EXTEND_TICKS ((`HPRS_PWR_EXTEND_MS * `HPRS_TICKS_PER_S) / 1000)
`define HPRS_SETTLE_CYCLES 2'h3

`endif

// ===== rtl/hprs_pkg.sv
// types of the host power and reset switch controller
package hprs_pkg;

  typedef enum logic [2:0] {
    HPRS_IDLE,
    HPRS_RST_PULSE,
    HPRS_PWR_PULSE,
    HPRS_PWR_EXTEND,
    HPRS_BOOT
  } hprs_state_t;

  typedef enum logic [1:0] {
    HPRS_MSG_NONE,
    HPRS_MSG_RESET,
    HPRS_MSG_PWR_ON,
    HPRS_MSG_PWR_OFF
  } hprs_msg_t;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    hprs_state_t st;
    logic [31:0] tick_cnt;
    logic [7:0] hold_cnt;
    logic [8:0] pulse_cnt;
    logic wait_release;
    logic [1:0] settle;
    logic sense_prev;
    logic pwr_idle_lvl;
    logic rst_idle_lvl;
    logic [7:0] cfg_mask;
    logic [7:0] cfg_len;
    logic cfg_sense_sel;
    logic [7:0] boot_mask;
    logic [7:0] boot_len;
    logic boot_sense_sel;
    logic pwr_o;
    logic pwr_oe;
    logic rst_o;
    logic rst_oe;
    logic blank;
    hprs_msg_t msg;
    logic self_reset;
    logic rsp_valid;
    logic [7:0] rsp_type;
    logic cmd_block;
  } hprs_regs_t;

endpackage : hprs_pkg

// ===== rtl/hprs_switch.sv
// host power and reset switch controller
`include "hprs_params.svh"

module hprs_switch
  import hprs_pkg::*;
#(
  parameter int TICK_CYCLES = `HPRS_TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_type,
  input wire logic [1:0] cmd_len,
  input wire logic [7:0] cmd_data0,
  input wire logic [7:0] cmd_data1,
  input wire logic [7:0] cmd_data2,
  input wire logic store_boot_state,
  output logic cmd_block,
  output logic rsp_valid,
  output logic [7:0] rsp_type,
  // keypad and sense pins
  input wire logic key_check,
  input wire logic key_cancel,
  input wire logic sense_gpio,
  input wire logic sense_power_header,
  // host power and reset lines
  input wire logic power_line_in,
  output logic power_line_out,
  output logic power_line_oe,
  input wire logic reset_line_in,
  output logic reset_line_out,
  output logic reset_line_oe,
  // display and device state
  output logic display_blank,
  output logic [1:0] msg_code,
  output logic self_reset,
  output logic [7:0] cfg_mask,
  output logic [7:0] cfg_len,
  output logic cfg_sense_sel
);

  hprs_regs_t q;
  hprs_regs_t next_q;

  logic tick_now;
  logic sense;
  logic check_key;
  logic cancel_key;
  logic rst_act;
  logic pwr_act;
  logic armed;
  logic [7:0] thr;
  logic [8:0] pwr_len;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    next_q.sync1 = {reset_line_in, power_line_in, sense_power_header, sense_gpio,
                    key_cancel, key_check};
    next_q.sync2 = q.sync1;
    next_q.rsp_valid = 1'b0;
    next_q.self_reset = 1'b0;

    // 1/32 s time base
    tick_now = (q.tick_cnt == 32'(TICK_CYCLES - 1));
    if (tick_now)
      next_q.tick_cnt = 32'h0;
    else
      next_q.tick_cnt = q.tick_cnt + 32'h1;

    sense = q.cfg_sense_sel ? q.sync2[`HPRS_SY_SENSE_HDR]
                            : q.sync2[`HPRS_SY_SENSE_GPIO];
    check_key = q.sync2[`HPRS_SY_CHECK];
    cancel_key = q.sync2[`HPRS_SY_CANCEL];
    next_q.sense_prev = sense;
    next_q.blank = q.cfg_mask[`HPRS_BIT_BLANK] & ~sense;

    // auto polarity drives against the level the line rests at
    rst_act = q.cfg_mask[`HPRS_BIT_AUTO_POL] ? ~q.rst_idle_lvl
                                             : q.cfg_mask[`HPRS_BIT_RESET_INV];
    pwr_act = q.cfg_mask[`HPRS_BIT_AUTO_POL] ? ~q.pwr_idle_lvl
                                             : q.cfg_mask[`HPRS_BIT_POWER_INV];
    // a zero length is taken as the default pulse
    pwr_len = (q.cfg_len == 8'h00) ? 9'(`HPRS_PWR_PULSE_DEF_TICKS)
                                   : {1'b0, q.cfg_len};

    // ----------------------------------------------------------------
    // host command
    // ----------------------------------------------------------------
    if (cmd_valid && !q.cmd_block && cmd_type == `HPRS_CMD_SWITCH_CFG
        && cmd_len != 2'h0)
    begin
      next_q.cfg_mask = cmd_data0;
      if (cmd_len >= 2'h2)
        next_q.cfg_len = cmd_data1;
      if (cmd_len == 2'h3 && cmd_data2 <= 8'h01)
        next_q.cfg_sense_sel = cmd_data2[0];
      next_q.rsp_valid = 1'b1;
      next_q.rsp_type = `HPRS_RSP_SWITCH_CFG;
    end
    if (store_boot_state)
    begin
      next_q.boot_mask = q.cfg_mask;
      next_q.boot_len = q.cfg_len;
      next_q.boot_sense_sel = q.cfg_sense_sel;
    end

    // ----------------------------------------------------------------
    // keypad arming
    // ----------------------------------------------------------------
    armed = 1'b0;
    thr = 8'h00;
    if (sense && q.cfg_mask[`HPRS_BIT_KEY_RESET] && check_key)
    begin
      armed = 1'b1;
      thr = 8'(`HPRS_RESET_HOLD_TICKS);
    end
    else if (!sense && q.cfg_mask[`HPRS_BIT_KEY_PWR_ON] && check_key)
    begin
      armed = 1'b1;
      thr = 8'(`HPRS_PWR_ON_PRESS_TICKS);
    end
    else if (sense && q.cfg_mask[`HPRS_BIT_KEY_PWR_OFF] && cancel_key)
    begin
      armed = 1'b1;
      thr = 8'(`HPRS_PWR_OFF_HOLD_TICKS);
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    unique case (q.st)
      HPRS_IDLE:
      begin
        if (q.settle != 2'h0)
          next_q.settle = q.settle - 2'h1;
        else
        begin
          // learn resting levels only once the line has stopped moving
          next_q.rst_idle_lvl = q.sync2[`HPRS_SY_RST_LINE];
          next_q.pwr_idle_lvl = q.sync2[`HPRS_SY_PWR_LINE];
        end
        next_q.pulse_cnt = 9'h0;
        if (q.wait_release)
        begin
          next_q.hold_cnt = 8'h0;
          if (!check_key && !cancel_key)
            next_q.wait_release = 1'b0;
        end
        else if (!armed)
          next_q.hold_cnt = 8'h0;
        else if (q.hold_cnt == thr)
        begin
          next_q.hold_cnt = 8'h0;
          next_q.wait_release = 1'b1;
          if (!sense)
          begin
            next_q.st = HPRS_PWR_PULSE;
            next_q.msg = HPRS_MSG_PWR_ON;
          end
          else if (check_key)
          begin
            next_q.st = HPRS_RST_PULSE;
            next_q.msg = HPRS_MSG_RESET;
          end
          else
          begin
            next_q.st = HPRS_PWR_PULSE;
            next_q.msg = HPRS_MSG_PWR_OFF;
          end
        end
        else if (tick_now)
          next_q.hold_cnt = q.hold_cnt + 8'h1;
        // host came up while the device idled on standby power
        if (q.settle == 2'h0 && sense && !q.sense_prev && !armed)
          next_q.st = HPRS_BOOT;
      end
      HPRS_RST_PULSE:
      begin
        if (tick_now)
          next_q.pulse_cnt = q.pulse_cnt + 9'h1;
        if (q.pulse_cnt == 9'(`HPRS_RESET_PULSE_TICKS))
        begin
          next_q.cmd_block = 1'b1;
          next_q.st = HPRS_BOOT;
        end
      end
      HPRS_PWR_PULSE:
      begin
        if (tick_now)
          next_q.pulse_cnt = q.pulse_cnt + 9'h1;
        if (q.pulse_cnt == pwr_len)
        begin
          next_q.pulse_cnt = 9'h0;
          if (q.msg == HPRS_MSG_PWR_ON)
            next_q.st = HPRS_BOOT;
          else if (cancel_key)
            next_q.st = HPRS_PWR_EXTEND;
          else
          begin
            next_q.st = HPRS_IDLE;
            next_q.msg = HPRS_MSG_NONE;
            next_q.settle = `HPRS_SETTLE_CYCLES;
          end
        end
      end
      HPRS_PWR_EXTEND:
      begin
        if (tick_now)
          next_q.pulse_cnt = q.pulse_cnt + 9'h1;
        if (!cancel_key || q.pulse_cnt == 9'(`HPRS_PWR_EXTEND_TICKS))
        begin
          next_q.st = HPRS_IDLE;
          next_q.msg = HPRS_MSG_NONE;
          next_q.settle = `HPRS_SETTLE_CYCLES;
        end
      end
      HPRS_BOOT:
      begin
        next_q.self_reset = 1'b1;
        next_q.cfg_mask = q.boot_mask;
        next_q.cfg_len = q.boot_len;
        next_q.cfg_sense_sel = q.boot_sense_sel;
        next_q.cmd_block = 1'b0;
        next_q.msg = HPRS_MSG_NONE;
        next_q.settle = `HPRS_SETTLE_CYCLES;
        next_q.hold_cnt = 8'h0;
        next_q.st = HPRS_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // line drive
    // ----------------------------------------------------------------
    next_q.rst_oe = (next_q.st == HPRS_RST_PULSE);
    next_q.rst_o = next_q.rst_oe & rst_act;
    next_q.pwr_oe = (next_q.st == HPRS_PWR_PULSE)
                    || (next_q.st == HPRS_PWR_EXTEND);
    next_q.pwr_o = next_q.pwr_oe & pwr_act;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= HPRS_IDLE;
      q.msg <= HPRS_MSG_NONE;
      q.settle <= `HPRS_SETTLE_CYCLES;
      q.pwr_idle_lvl <= 1'b1;
      q.rst_idle_lvl <= 1'b1;
      q.cfg_mask <= `HPRS_MASK_RST;
      q.cfg_len <= `HPRS_LEN_RST;
      q.cfg_sense_sel <= `HPRS_SENSE_SEL_RST;
      q.boot_mask <= `HPRS_MASK_RST;
      q.boot_len <= `HPRS_LEN_RST;
      q.boot_sense_sel <= `HPRS_SENSE_SEL_RST;
    end
    else
      q <= next_q;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_block = q.cmd_block;
  assign rsp_valid = q.rsp_valid;
  assign rsp_type = q.rsp_type;
  assign power_line_out = q.pwr_o;
  assign power_line_oe = q.pwr_oe;
  assign reset_line_out = q.rst_o;
  assign reset_line_oe = q.rst_oe;
  assign display_blank = q.blank;
  assign msg_code = q.msg;
  assign self_reset = q.self_reset;
  assign cfg_mask = q.cfg_mask;
  assign cfg_len = q.cfg_len;
  assign cfg_sense_sel = q.cfg_sense_sel;

endmodule : hprs_switch

// ===== sim/hprs_host_model.sv
// host board model: switch inputs with pull-ups, wire levels fed back
module hprs_host_model
(
  // lines from the controller
  input wire logic power_line_out,
  input wire logic power_line_oe,
  input wire logic reset_line_out,
  input wire logic reset_line_oe,
  // wire levels seen by the controller
  output logic power_line_in,
  output logic reset_line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // released lines float up to the board pull-up
  assign power_line_in = power_line_oe ? power_line_out : 1'b1;
  assign reset_line_in = reset_line_oe ? reset_line_out : 1'b1;
endmodule : hprs_host_model

// ===== sim/hprs_switch_props.sv
// assertion checker of the host power and reset switch controller
module hprs_switch_props
  import hprs_pkg::*;
#(
  parameter int TICK_CYCLES = 4
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_type,
  input wire logic [1:0] cmd_len,
  input wire logic [7:0] cmd_data0,
  input wire logic [7:0] cmd_data1,
  input wire logic [7:0] cmd_data2,
  input wire logic cmd_block,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_type,
  // lines and configuration
  input wire logic power_line_out,
  input wire logic power_line_oe,
  input wire logic reset_line_out,
  input wire logic reset_line_oe,
  input wire logic [7:0] cfg_mask,
  input wire logic [7:0] cfg_len,
  input wire logic cfg_sense_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic take;
  logic [11:0] oe_run;
  assign take = cmd_valid && !cmd_block && cmd_type == 8'h1C && cmd_len != 2'h0;
  // longest drive: 255 ticks of pulse plus 160 of extension, two ticks slack
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      oe_run <= 12'h000;
    else
      oe_run <= power_line_oe ? oe_run + 12'h001 : 12'h000;
  property p_reply; take |=> rsp_valid && rsp_type == 8'h5C; endproperty
  a_reply: assert property (p_reply) else $error("reply missing");
  property p_stray; rsp_valid |-> $past(take); endproperty
  a_stray: assert property (p_stray) else $error("reply without command");
  property p_blocked; cmd_block |=> !rsp_valid; endproperty
  a_blocked: assert property (p_blocked) else $error("reply while blocked");
  property p_mask; take |=> cfg_mask == $past(cmd_data0); endproperty
  a_mask: assert property (p_mask) else $error("mask not taken");
  property p_len; take && cmd_len >= 2'h2 |=> cfg_len == $past(cmd_data1); endproperty
  a_len: assert property (p_len) else $error("length not taken");
  property p_sense;
    take && cmd_len == 2'h3 |=> cfg_sense_sel ==
      ($past(cmd_data2) > 8'h01 ? $past(cfg_sense_sel) : $past(cmd_data2[0]));
  endproperty
  a_sense: assert property (p_sense) else $error("sense select wrong");
  property p_float;
    !power_line_oe && !reset_line_oe |-> !power_line_out && !reset_line_out;
  endproperty
  a_float: assert property (p_float) else $error("released line driven");
  property p_rst_pol; reset_line_oe && !cfg_mask[0] |-> reset_line_out == cfg_mask[1]; endproperty
  a_rst_pol: assert property (p_rst_pol) else $error("reset level wrong");
  property p_pwr_pol; power_line_oe && !cfg_mask[0] |-> power_line_out == cfg_mask[2]; endproperty
  a_pwr_pol: assert property (p_pwr_pol) else $error("power level wrong");
  property p_extend; oe_run <= 417 * TICK_CYCLES; endproperty
  a_extend: assert property (p_extend) else $error("power drive too long");
  c_reply: cover property (take);
  c_pwr: cover property ($rose(power_line_oe));
  c_rst: cover property ($rose(reset_line_oe));
endmodule : hprs_switch_props

bind hprs_switch hprs_switch_props #(.TICK_CYCLES(TICK_CYCLES)) u_hprs_switch_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_type(cmd_type),
  .cmd_len(cmd_len), .cmd_data0(cmd_data0), .cmd_data1(cmd_data1), .cmd_data2(cmd_data2),
  .cmd_block(cmd_block), .rsp_valid(rsp_valid), .rsp_type(rsp_type),
  .power_line_out(power_line_out), .power_line_oe(power_line_oe),
  .reset_line_out(reset_line_out), .reset_line_oe(reset_line_oe),
  .cfg_mask(cfg_mask), .cfg_len(cfg_len), .cfg_sense_sel(cfg_sense_sel)
);

// ===== sim/hprs_switch_tb.sv
// testbench of the host power and reset switch controller
module hprs_switch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_type = 8'h00, cmd_data0 = 8'h00, cmd_data1 = 8'h00, cmd_data2 = 8'h00;
  logic [1:0] cmd_len = 2'h0;
  logic store_boot_state = 1'b0, key_check = 1'b0, key_cancel = 1'b0;
  logic sense_gpio = 1'b0, sense_power_header = 1'b1;
  logic cmd_block, rsp_valid, power_line_in, power_line_out, power_line_oe;
  logic reset_line_in, reset_line_out, reset_line_oe, display_blank, self_reset, cfg_sense_sel;
  logic [7:0] rsp_type, cfg_mask, cfg_len;
  logic [1:0] msg_code;
  int err_total = 0;
  int total_checks = 0;
  int w;
  always #5 clk_sys = ~clk_sys;
  hprs_switch #(.TICK_CYCLES(T)) u_hprs_switch (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_type(cmd_type),
    .cmd_len(cmd_len), .cmd_data0(cmd_data0), .cmd_data1(cmd_data1), .cmd_data2(cmd_data2),
    .store_boot_state(store_boot_state), .cmd_block(cmd_block), .rsp_valid(rsp_valid),
    .rsp_type(rsp_type), .key_check(key_check), .key_cancel(key_cancel),
    .sense_gpio(sense_gpio), .sense_power_header(sense_power_header),
    .power_line_in(power_line_in), .power_line_out(power_line_out),
    .power_line_oe(power_line_oe), .reset_line_in(reset_line_in),
    .reset_line_out(reset_line_out), .reset_line_oe(reset_line_oe),
    .display_blank(display_blank), .msg_code(msg_code), .self_reset(self_reset),
    .cfg_mask(cfg_mask), .cfg_len(cfg_len), .cfg_sense_sel(cfg_sense_sel)
  );
  hprs_host_model u_hprs_host_model (
    .power_line_out(power_line_out), .power_line_oe(power_line_oe),
    .reset_line_out(reset_line_out), .reset_line_oe(reset_line_oe),
    .power_line_in(power_line_in), .reset_line_in(reset_line_in)
  );
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic send(input logic [7:0] ty, input logic [1:0] len, input logic [7:0] d0,
                      input logic [7:0] d1, input logic [7:0] d2, input logic exp);
    cmd_valid = 1'b1;
    cmd_type = ty;
    cmd_len = len;
    cmd_data0 = d0;
    cmd_data1 = d1;
    cmd_data2 = d2;
    tick(1);
    cmd_valid = 1'b0;
    check("reply", {rsp_valid, exp ? rsp_type : 8'h5C}, {exp, 8'h5C});
    tick(1);
  endtask : send
  // watched output: 0 power drive, 1 reset drive, 2 reboot pulse
  function automatic logic sel(input int s);
    return s == 0 ? power_line_oe : s == 1 ? reset_line_oe : self_reset;
  endfunction : sel
  task automatic wait_hi(input int s, input int lim, output int n);
    n = 0;
    while (sel(s) !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    check("wait", n < lim, 1'b1);
    if (n >= lim)
      conclude();
  endtask : wait_hi
  task automatic width(input int s, output int n);
    n = 0;
    while (sel(s) === 1'b1 && n < 4000)
    begin
      tick(1);
      n++;
    end
    check("width", n < 4000, 1'b1);
    if (n >= 4000)
      conclude();
  endtask : width
  initial
  begin
    tick(4);
    rst_n = 1'b1;
    tick(1);
    check("cfg", {cfg_mask, cfg_len}, 16'h0020);
    check("idle", {cfg_sense_sel, power_line_oe, reset_line_oe}, 3'h4);
    send(8'h1C, 2'h1, 8'h84, 8'h09, 8'h09, 1'b1);
    check("len", cfg_len, 8'h20);
    send(8'h1C, 2'h2, 8'h84, 8'h02, 8'h09, 1'b1);
    send(8'h1C, 2'h3, 8'h84, 8'h02, 8'h02, 1'b1);
    send(8'h1D, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0);
    send(8'h1C, 2'h0, 8'h00, 8'h00, 8'h00, 1'b0);
    check("cfg", {cfg_mask, cfg_len, 3'h0, cfg_sense_sel}, 20'h84021);
    key_cancel = 1'b1;
    wait_hi(0, 200 * T, w);
    check("hold", w >= 126 * T && w <= 133 * T, 1'b1);
    check("off", {power_line_out, msg_code}, 3'h7);
    key_cancel = 1'b0;
    width(0, w);
    check("pwr width", w >= T && w <= 3 * T + 2, 1'b1);
    tick(2);
    key_cancel = 1'b1;
    wait_hi(0, 200 * T, w);
    width(0, w);
    key_cancel = 1'b0;
    check("extend", w >= 150 * T && w <= 164 * T, 1'b1);
    send(8'h1C, 2'h1, 8'h22, 8'h00, 8'h00, 1'b1);
    store_boot_state = 1'b1;
    tick(1);
    store_boot_state = 1'b0;
    send(8'h1C, 2'h2, 8'h22, 8'h05, 8'h00, 1'b1);
    key_check = 1'b1;
    wait_hi(1, 200 * T, w);
    check("hold", w >= 126 * T && w <= 133 * T, 1'b1);
    check("rst", {reset_line_out, power_line_oe, msg_code}, 4'h9);
    key_check = 1'b0;
    width(1, w);
    check("rst width", w >= 31 * T && w <= 35 * T, 1'b1);
    check("block", cmd_block, 1'b1);
    cmd_valid = 1'b1;
    cmd_len = 2'h1;
    cmd_data0 = 8'h00;
    tick(1);
    cmd_valid = 1'b0;
    check("ignored", {rsp_valid, cmd_block}, 2'h0);
    check("reboot", self_reset, 1'b1);
    tick(1);
    check("boot", {cfg_mask, cfg_len, 3'h0, cmd_block}, 20'h22020);
    send(8'h1C, 2'h3, 8'h55, 8'h03, 8'h00, 1'b1);
    tick(4);
    check("blank", display_blank, 1'b1);
    key_check = 1'b1;
    wait_hi(0, 40 * T, w);
    check("press", w >= 7 * T && w <= 12 * T, 1'b1);
    check("on", {power_line_out, msg_code}, 3'h2);
    key_check = 1'b0;
    width(0, w);
    check("pwr width", w >= 2 * T && w <= 4 * T + 2, 1'b1);
    wait_hi(2, 100 * T, w);
    tick(8);
    sense_power_header = 1'b0;
    tick(8);
    sense_power_header = 1'b1;
    wait_hi(2, 20, w);
    conclude();
  end
endmodule : hprs_switch_tb
